// ### testbench/nmi_reset_source.sv
// far side model: nmi pin source and reset pin driver
// assumes the bench moves sel, wake and rst_req just after clk rises
module nmi_reset_source
(
   input  wire logic sel,     // edge the device is set to look for
   input  wire logic wake,    // high: drive the wake level
   input  wire logic rst_req, // high: request power-on reset
   output logic      nmi_pin, // to the nmi pin
   output logic      nrst     // to the reset pin
);
   timeunit 1ns;
   timeprecision 1ps;
   // idle level opposite the wake edge, wake level per sel
   // wake level held for as long as wake stays high
   always_comb nmi_pin = wake ? sel : ~sel;
   always_comb nrst = ~rst_req;
endmodule // nmi_reset_source

// ### testbench/standby_exit_control_bench.sv
// self-checking bench for the standby exit controller
// assumes the warm-up counter shortened to 3 bits, no prescale
`include "standby_params.svh"
module standby_exit_control_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import standby_pkg::*;
   logic        clk, nrst, nmi_pin, irq_other, sleep_exec, wr, rd;
   logic [7:0]  addr, pin_func, port_data;
   logic [31:0] wdata, rdata, rv;
   clk_gate_t   gate;
   logic        in_standby, retain, nmi_exc, irq, sel, wake, rst_req;
   int          bad_count, n_checks;

   nmi_reset_source i_src (.sel(sel), .wake(wake), .rst_req(rst_req),
      .nmi_pin(nmi_pin), .nrst(nrst));
   standby_exit_ctrl #(.WDT_CNT_W(3), .PRE_BASE(0)) i_dut (.clk(clk), .nrst(nrst),
      .nmi_pin(nmi_pin), .irq_other(irq_other), .sleep_exec(sleep_exec),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .gate(gate), .in_standby(in_standby), .retain(retain),
      .nmi_exc(nmi_exc), .irq(irq), .pin_func(pin_func), .port_data(port_data));

   // ****************************************
   // compare and bus tasks
   // ****************************************
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[FAIL] %0t %s got %h want %h", $time, m, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp, input string m);
      chk_val({31'h0, got}, {31'h0, exp}, m);
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wr <= 1'b1; addr <= a; wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      rd <= 1'b1; addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic wait_gate(input logic [3:0] exp, input string m);
      for (int i = 0; i < 40 && gate !== exp; i++)
         @(posedge clk) #1;
      chk_val({28'h0, gate}, {28'h0, exp}, m);
   endtask
   task automatic pulse_reset();
      @(posedge clk);
      rst_req <= 1'b1; wake <= 1'b0;
      @(posedge clk);
      rst_req <= 1'b0;
      #1;
   endtask
   task automatic enter_standby(input logic s);
      @(posedge clk);
      sel <= s;
      wr_reg(`ADDR_CTRL, {27'h0, 3'h0, s, 1'b1});
      @(posedge clk);
      sleep_exec <= 1'b1;
      @(posedge clk);
      sleep_exec <= 1'b0;
      #1;
      chk_bit(in_standby, 1'b1, "standby entry");
      chk_val({28'h0, gate}, 32'h0, "standby gates");
      chk_bit(retain, 1'b1, "retain");
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset_values();
      logic [7:0] regs [7];
      regs = '{`ADDR_CTRL, `ADDR_STAT, `ADDR_MASK, `ADDR_STATE, `ADDR_PINF, `ADDR_PORT, 8'h20};
      foreach (regs[i])
      begin
         rd_reg(regs[i], rv);
         chk_val(rv, 32'h0, "reset or unmapped read");
      end
      chk_val({28'h0, gate}, 32'hF, "run gates");
      chk_bit(irq, 1'b0, "irq at reset");
   endtask
   // wake on each edge polarity with retention and other irq ignored
   task automatic t_wake(input logic s);
      int n;
      wr_reg(`ADDR_MASK, 32'h4);
      wr_reg(`ADDR_PINF, {24'h0, 8'hA5 ^ {8{s}}});
      wr_reg(`ADDR_PORT, 32'h3C);
      enter_standby(s);
      wr_reg(`ADDR_PINF, 32'hFF);
      @(posedge clk);
      irq_other <= 1'b1;
      @(posedge clk);
      irq_other <= 1'b0;
      repeat (10) @(posedge clk);
      #1 chk_bit(in_standby, 1'b1, "other irq woke");
      chk_val({28'h0, gate}, 32'h0, "other irq gated");
      rd_reg(`ADDR_STATE, rv);
      chk_val(rv, 32'h1, "state in standby");
      @(posedge clk);
      wake <= 1'b1;
      wait_gate(4'h9, "warm-up gates");
      // 3-bit counter stepped every cycle: eight cycles of warm-up
      for (n = 0; n < 200 && nmi_exc !== 1'b1; n++)
         @(posedge clk) #1;
      chk_val(n, 32'd8, "warm-up length");
      chk_bit(nmi_exc, 1'b1, "nmi exception");
      chk_val({28'h0, gate}, 32'hF, "wake gates");
      @(posedge clk);
      wake <= 1'b0;
      #1 chk_val({24'h0, pin_func}, {24'h0, 8'hA5 ^ {8{s}}}, "pin func");
      chk_val({24'h0, port_data}, 32'h3C, "port data");
      rd_reg(`ADDR_CTRL, rv);
      chk_val(rv, {27'h0, 3'h0, s, 1'b1}, "ctrl kept");
      rd_reg(`ADDR_STAT, rv);
      chk_bit(rv[`STAT_WAKE], 1'b1, "wake status");
      chk_bit(irq, 1'b1, "irq on wake");
      wr_reg(`ADDR_STAT, 32'h7);
      chk_bit(irq, 1'b0, "irq cleared");
   endtask
   task automatic t_reset_exit();
      enter_standby(1'b1);
      pulse_reset();
      chk_bit(in_standby, 1'b0, "reset in standby");
      chk_val({28'h0, gate}, 32'hF, "reset gates");
      enter_standby(1'b1);
      @(posedge clk);
      wake <= 1'b1;
      wait_gate(4'h9, "warm-up again");
      pulse_reset();
      chk_val({28'h0, gate}, 32'hF, "reset in warm-up");
      for (int i = 0; i < 30; i++)
         @(posedge clk) #1 chk_bit(nmi_exc | in_standby, 1'b0, "exit kept");
   endtask
   // run-mode nmi: the falling edge is taken once, the rising one never
   task automatic t_run_edge();
      logic [3:0] hits;
      @(posedge clk);
      sel <= 1'b0;
      wake <= 1'b0;
      repeat (6) @(posedge clk);
      for (int k = 0; k < 2; k++)
      begin
         hits = 4'h0;
         @(posedge clk);
         wake <= (k == 0);
         repeat (8) @(posedge clk) #1 hits += {3'h0, nmi_exc};
         chk_val({28'h0, hits}, {31'h0, k == 0}, "run nmi pulses");
      end
      rd_reg(`ADDR_STAT, rv);
      chk_bit(rv[`STAT_NMI], 1'b1, "nmi status");
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial
   begin
      #20000;
      bad_count++;
      end_of_test();
   end
   initial
   begin
      {irq_other, sleep_exec, wr, rd, sel, wake} = '0;
      addr = 8'h00; wdata = 32'h0; rst_req = 1'b1;
      bad_count = 0; n_checks = 0;
      repeat (2) @(posedge clk);
      rst_req <= 1'b0;
      @(posedge clk);
      t_reset_values();
      t_wake(1'b0);
      t_wake(1'b1);
      t_reset_exit();
      t_run_edge();
      end_of_test();
   end
endmodule // standby_exit_control_bench

// ### verilog/nmi_edge_latch.sv
// clockless catch of the selected nmi pin edge
// assumes sel is steady whenever arm is high
module nmi_edge_latch
(
   input  wire logic nmi_pin,   // raw pin level
   input  wire logic sel,       // 0 falling, 1 rising
   input  wire logic arm,       // high while in standby
   output logic      caught     // selected edge seen
);

   logic det_clk;

   // edge polarity mux
   // the pin itself clocks the flop, so sel must not move while armed
   assign det_clk = sel ? nmi_pin : ~nmi_pin;

   always_ff @(posedge det_clk or negedge arm)
   begin
      if (!arm)
         caught <= 1'b0;
      else
         caught <= 1'b1;
   end

endmodule // nmi_edge_latch

// ### verilog/standby_exit_ctrl.sv
// standby entry and exit sequencing with clock gating
// assumes a register master on a plain strobe port and
// an nmi pin driven from outside the clock domain
//
// Added by the designer: the register addresses and strobed register access.
`include "standby_params.svh"
module standby_exit_ctrl
   import standby_pkg::*;
#(
   parameter int WDT_CNT_W = 8,  // warm-up counter width
   parameter int PRE_BASE  = 1   // prescale exponent at select 0
)
(
   input  wire logic        clk,        // system clock
   input  wire logic        nrst,       // reset pin, active low
   input  wire logic        nmi_pin,    // nmi pin
   input  wire logic        irq_other,  // any other interrupt
   input  wire logic        sleep_exec, // sleep instruction pulse
   input  wire logic [7:0]  addr,       // register address
   input  wire logic [31:0] wdata,      // write data
   input  wire logic        wr,         // write strobe
   input  wire logic        rd,         // read strobe
   output logic      [31:0] rdata,      // read data, next cycle
   output clk_gate_t        gate,       // clock enables
   output logic             in_standby, // standby or warm-up state
   output logic             retain,     // hold retained state
   output logic             nmi_exc,    // nmi exception start
   output logic             irq,        // unmasked event pending
   output logic      [7:0]  pin_func,   // pin function setting
   output logic      [7:0]  port_data   // port output data
);

   // ****************************************
   // state
   // ****************************************
   pstate_t              state_r;
   pstate_t              state_nxt;
   ctrl_t                ctrl_r;
   logic [2:0]           stat_r;
   logic [2:0]           mask_r;
   logic [7:0]           pinf_r;
   logic [7:0]           port_r;
   logic [31:0]          rdata_r;
   logic [`WDT_PRE_W-1:0] pre_r;
   logic [WDT_CNT_W-1:0] cnt_r;
   logic                 arm_r;
   logic                 caught;
   logic                 lat_s1;
   logic                 lat_s2;
   logic                 lat_s3;
   logic                 pin_s1;
   logic                 pin_s2;
   logic                 pin_s3;
   logic                 lvl_r;
   logic                 wake_seen;
   logic                 run_edge;
   logic                 tick;
   logic                 ovf;
   logic                 wr_ok;
   logic [2:0]           evt;

   function automatic logic pre_tick(
      input logic [`WDT_PRE_W-1:0] pre,
      input logic [2:0]            cks
   );
      logic [`WDT_PRE_W-1:0] m;
      int                    sh;
      sh = PRE_BASE + `WDT_PRE_STEP * int'(cks);
      m = `WDT_PRE_W'((33'h1 << sh) - 33'h1);
      return (pre & m) == m;
   endfunction

   // ****************************************
   // edge catch while clocks are stopped
   // ****************************************
   nmi_edge_latch u_latch
   (
      .nmi_pin (nmi_pin),
      .sel     (ctrl_r.irq_edge_select),
      .arm     (arm_r),
      .caught  (caught)
   );

   always_ff @(posedge clk)
   begin
      if (!nrst)
         arm_r <= 1'b0;
      else
         arm_r <= (state_nxt == ST_STANDBY);
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
         {lat_s3, lat_s2, lat_s1} <= 3'h0;
      else
         {lat_s3, lat_s2, lat_s1} <= {lat_s2, lat_s1, caught};
   end

   assign wake_seen = lat_s2 & lat_s3;

   // ****************************************
   // nmi pin level in normal running
   // ****************************************
   always_ff @(posedge clk)
   begin
      if (!nrst)
         {pin_s3, pin_s2, pin_s1} <= 3'h0;
      else
         {pin_s3, pin_s2, pin_s1} <= {pin_s2, pin_s1, nmi_pin};
   end

   // level tracks silently in standby so the wake edge is not
   // counted a second time once running again
   always_ff @(posedge clk)
   begin
      if (!nrst)
         lvl_r <= 1'b0;
      else if (pin_s2 == pin_s3)
         lvl_r <= pin_s3;
   end

   assign run_edge = (state_r == ST_RUN) && (pin_s2 == pin_s3)
                     && (pin_s3 != lvl_r)
                     && (pin_s3 == ctrl_r.irq_edge_select);

   // ****************************************
   // sequencer
   // ****************************************
   assign tick = pre_tick(pre_r, ctrl_r.wdt_clock_select);
   assign ovf  = tick && (&cnt_r);

   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         ST_RUN:
            if (sleep_exec && ctrl_r.standby_select_bit)
               state_nxt = ST_STANDBY;
         ST_STANDBY:
            if (wake_seen)
               state_nxt = ST_WARMUP;
         ST_WARMUP:
            if (ovf)
               state_nxt = ST_WAKE;
         ST_WAKE:
            state_nxt = ST_RUN;
         default:
            state_nxt = ST_RUN;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
         state_r <= ST_RUN;
      else
         state_r <= state_nxt;
   end

   always_ff @(posedge clk)
   begin
      if (!nrst || state_r != ST_WARMUP)
      begin
         pre_r <= '0;
         cnt_r <= '0;
      end
      else
      begin
         pre_r <= pre_r + `WDT_PRE_W'(1);
         if (tick)
            cnt_r <= cnt_r + WDT_CNT_W'(1);
      end
   end

   // ****************************************
   // clock gating and outputs
   // ****************************************
   always_comb
   begin
      gate = '0;
      case (state_r)
         ST_RUN, ST_WAKE:
            gate = 4'hF;
         ST_STANDBY:
            // oscillator restarts on the raw catch
            gate.osc_en = caught;
         ST_WARMUP:
         begin
            gate.osc_en = 1'b1;
            gate.wdt_en = 1'b1;
         end
         default:
            gate = 4'hF;
      endcase
   end

   assign in_standby = (state_r == ST_STANDBY) || (state_r == ST_WARMUP);
   assign retain    = in_standby;
   assign nmi_exc   = (state_r == ST_WAKE) || run_edge;
   assign irq       = |(stat_r & mask_r);
   assign rdata     = rdata_r;
   assign pin_func  = pinf_r;
   assign port_data = port_r;

   // ****************************************
   // registers
   // ****************************************
   // cpu is halted in standby and warm-up and writes are taken in run only, so nothing may move the retained set
   assign wr_ok = wr && (state_r == ST_RUN);

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         ctrl_r <= `CTRL_RST;
         mask_r <= `MASK_RST;
         pinf_r <= `PINF_RST;
         port_r <= `PORT_RST;
      end
      else if (wr_ok)
      begin
         case (addr)
            `ADDR_CTRL: ctrl_r <= wdata[4:0];
            `ADDR_MASK: mask_r <= wdata[2:0];
            `ADDR_PINF: pinf_r <= wdata[7:0];
            `ADDR_PORT: port_r <= wdata[7:0];
            default: ;
         endcase
      end
   end

   always_comb
   begin
      evt = '0;
      evt[`STAT_NMI]   = nmi_exc;
      evt[`STAT_ENTER] = (state_r == ST_RUN) && (state_nxt == ST_STANDBY);
      evt[`STAT_WAKE]  = (state_r == ST_WAKE);
   end

   // set wins over a same-cycle write-one clear
   always_ff @(posedge clk)
   begin
      if (!nrst)
         stat_r <= `STAT_RST;
      else if (wr_ok && addr == `ADDR_STAT)
         stat_r <= (stat_r & ~wdata[2:0]) | evt;
      else
         stat_r <= stat_r | evt;
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
         rdata_r <= '0;
      else if (rd)
      begin
         case (addr)
            `ADDR_CTRL:  rdata_r <= {27'h0, ctrl_r};
            `ADDR_STAT:  rdata_r <= {29'h0, stat_r};
            `ADDR_MASK:  rdata_r <= {29'h0, mask_r};
            `ADDR_STATE: rdata_r <= {22'h0, 8'(cnt_r), state_r};
            `ADDR_PINF:  rdata_r <= {24'h0, pinf_r};
            `ADDR_PORT:  rdata_r <= {24'h0, port_r};
            default:     rdata_r <= '0;
         endcase
      end
      else
         rdata_r <= '0;
   end

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   property p_retain;
      (state_r != ST_RUN) |=> $stable(ctrl_r) && $stable(pinf_r)
                              && $stable(port_r);
   endproperty
   a_retain: assert property (p_retain)
      else $error("retained register changed outside run");

   property p_only_nmi;
      (state_r == ST_STANDBY) && !wake_seen |=> state_r == ST_STANDBY;
   endproperty
   a_only_nmi: assert property (p_only_nmi)
      else $error("standby left without nmi");

   property p_osc;
      (state_r == ST_STANDBY) |-> gate.osc_en == caught;
   endproperty
   a_osc: assert property (p_osc)
      else $error("oscillator enable does not follow edge catch");

   property p_wdt_only;
      (state_r == ST_WARMUP) |-> gate.wdt_en && !gate.cpu_en
                                 && !gate.periph_en;
   endproperty
   a_wdt_only: assert property (p_wdt_only)
      else $error("clock leaked beyond watchdog in warm-up");

   property p_wake;
      (state_r == ST_WARMUP) && ovf |=> nmi_exc && gate.cpu_en
                                        ##1 state_r == ST_RUN;
   endproperty
   a_wake: assert property (p_wake)
      else $error("overflow did not wake the chip");

   property p_reset;
      @(posedge clk) disable iff (1'b0)
         !nrst |=> state_r == ST_RUN && !nmi_exc && gate.cpu_en;
   endproperty
   a_reset: assert property (p_reset)
      else $error("reset did not return to run");

   property p_edge;
      run_edge |-> nmi_exc ##1 stat_r[`STAT_NMI];
   endproperty
   a_edge: assert property (p_edge)
      else $error("accepted edge not reported");

   property p_wrong_edge;
      (state_r == ST_RUN) && nmi_exc
      |-> (pin_s3 == ctrl_r.irq_edge_select) && (pin_s3 != $past(pin_s3));
   endproperty
   a_wrong_edge: assert property (p_wrong_edge)
      else $error("unselected edge raised nmi");

   property p_entry;
      (state_r == ST_RUN) && sleep_exec && ctrl_r.standby_select_bit
      |=> in_standby && !gate.cpu_en;
   endproperty
   a_entry: assert property (p_entry)
      else $error("sleep with standby bit did not enter standby");

   property p_halt;
      (state_r == ST_STANDBY) |-> !gate.cpu_en && !gate.periph_en
                                  && !gate.wdt_en && retain;
   endproperty
   a_halt: assert property (p_halt)
      else $error("clock running in standby");

   property p_sync;
      (state_r == ST_STANDBY) && caught |-> ##[1:4] state_r != ST_STANDBY;
   endproperty
   a_sync: assert property (p_sync)
      else $error("caught edge not taken up");

   c_full_exit: cover property (state_r == ST_WARMUP ##1 state_r == ST_WAKE);
   c_run_nmi:   cover property (run_edge);
   c_enter:     cover property (state_r == ST_RUN ##1 state_r == ST_STANDBY);
   c_rst_warm:  cover property (disable iff (1'b0) state_r == ST_WARMUP && !nrst);
   c_other_irq: cover property (state_r == ST_STANDBY && irq_other);

endmodule // standby_exit_ctrl

// ### verilog/standby_params.svh
// constants for the standby exit controller
// assumes a single 250 MHz clk and a synchronous active-low nrst
//
// How it works
// - retained registers frozen while in standby
// - only nmi edge or reset end standby
// - selected nmi edge restarts the oscillator
// - warm-up clock reaches the watchdog only
// - watchdog overflow wakes chip, starts nmi
// - reset pin low ends standby at once
// - edge select 0 falling, 1 rising
// - sleep with standby bit set enters standby
// - standby halts cpu and peripheral clocks
`ifndef STANDBY_PARAMS_SVH
`define STANDBY_PARAMS_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define ADDR_CTRL   8'h00
`define ADDR_STAT   8'h04
`define ADDR_MASK   8'h08
`define ADDR_STATE  8'h0C
`define ADDR_PINF   8'h10
`define ADDR_PORT   8'h14

// ****************************************
// field positions and reset values
// ****************************************
`define STAT_NMI    0
`define STAT_ENTER  1
`define STAT_WAKE   2
`define CTRL_RST    5'h00
`define MASK_RST    3'h0
`define STAT_RST    3'h0
`define PINF_RST    8'h00
`define PORT_RST    8'h00

// ****************************************
// watchdog warm-up timing
// ****************************************
`define WDT_PRE_W   16
`define WDT_PRE_STEP 2

`endif

// ### verilog/standby_pkg.sv
// types shared by the standby exit controller
// assumes standby_params.svh supplies the numbers
package standby_pkg;

   typedef enum logic [1:0] {
      ST_RUN,
      ST_STANDBY,
      ST_WARMUP,
      ST_WAKE
   } pstate_t;

   // bit 4:2 clock select, bit 1 edge select, bit 0 standby
   typedef struct packed {
      logic [2:0] wdt_clock_select;
      logic       irq_edge_select;
      logic       standby_select_bit;
   } ctrl_t;

   typedef struct packed {
      logic osc_en;
      logic cpu_en;
      logic periph_en;
      logic wdt_en;
   } clk_gate_t;

endpackage
